// ===== aps_pkg.sv
// Package for the parallel sample output block: widths, latency, carriers
package aps_pkg;
   localparam int SAMPLE_W       = 13;
   localparam int LATENCY_CYC    = 4;
   localparam int CLK_PERIOD_PS  = 10000;
   localparam int SCLK_PERIOD_NS = 4;
   localparam int SCLK_HIGH_NS   = 2;
   localparam logic [SAMPLE_W-1:0] MID_CODE = 13'h1000;
   localparam logic [SAMPLE_W-1:0] RST_WORD = 13'h0000;
   localparam logic                RST_STRB = 1'b1;

   // Offset-binary sample code (sign bit already flipped) plus its over-range mark
   typedef struct packed {
      logic                over;
      logic [SAMPLE_W-1:0] code;
   } aps_sample_t;
endpackage

// ===== aps_sample_out.sv
// Parallel sample output stage with latency pipe, over-range flag and ready strobe
`timescale 1ns/1ps
`default_nettype none
module aps_sample_out
   import aps_pkg::*;
#(
   parameter int WIDTH   = SAMPLE_W,
   parameter int LATENCY = LATENCY_CYC
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Sample clock from outside and the digitised front-end value
   input  wire logic             sample_clk,
   input  wire logic [WIDTH-1:0] analog_input_pair,
   input  wire logic             analog_over,
   // Parallel output toward capture logic
   output var  logic [WIDTH-1:0] sample_word,
   output var  logic             over_range_flag,
   output var  logic             sample_ready_strobe
);
   // The sample clock is far slower than ideal; edges are seen at clk rate,
   // so the real part's sub-ns skews become whole clk cycles here.
   logic       sclk_s1_r;
   logic       sclk_s2_r;
   logic       sclk_d_r;
   logic       rise;
   logic       fall;
   aps_sample_t pipe_r [LATENCY];
   aps_sample_t conv_nxt;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sclk_s1_r <= 1'b0;
         sclk_s2_r <= 1'b0;
         sclk_d_r  <= 1'b0;
      end else begin
         sclk_s1_r <= sample_clk;
         sclk_s2_r <= sclk_s1_r;
         sclk_d_r  <= sclk_s2_r;
      end
   end

   assign rise = sclk_s2_r & ~sclk_d_r;
   assign fall = ~sclk_s2_r & sclk_d_r;

   // Two's complement to offset binary: flip the sign bit
   always_comb begin
      conv_nxt.over = analog_over;
      conv_nxt.code = analog_input_pair ^ {1'b1, {(WIDTH-1){1'b0}}};
   end

   // Latency pipe advances once per sample-clock rise
   genvar g;
   generate
      for (g = 0; g < LATENCY; g++) begin : g_pipe
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               pipe_r[g] <= '0;
            end else if (rise) begin
               if (g == 0) begin
                  pipe_r[g] <= conv_nxt;
               end else begin
                  pipe_r[g] <= pipe_r[g-1];
               end
            end
         end
      end
   endgenerate

   // Output word and flag update on the fall, with the strobe rise
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sample_word     <= RST_WORD;
         over_range_flag <= 1'b0;
      end else if (fall) begin
         sample_word     <= pipe_r[LATENCY-1].code;
         over_range_flag <= pipe_r[LATENCY-1].over;
      end
   end

   // Strobe follows the clock: low after rise, high after fall
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sample_ready_strobe <= RST_STRB;
      end else if (rise) begin
         sample_ready_strobe <= 1'b0;
      end else if (fall) begin
         sample_ready_strobe <= 1'b1;
      end
   end

   a_strobe_rise_word: assert property (@(posedge clk) disable iff (!nrst)
      fall |=> sample_ready_strobe && sample_word == $past(pipe_r[LATENCY-1].code))
      else $error("word or strobe did not update on fall");

   a_strobe_fall_rise: assert property (@(posedge clk) disable iff (!nrst)
      rise |=> !sample_ready_strobe)
      else $error("strobe did not fall after rise");

   a_word_stable_low: assert property (@(posedge clk) disable iff (!nrst)
      !fall |=> $stable(sample_word) && $stable(over_range_flag))
      else $error("word changed outside the fall");

   a_pipe_first: assert property (@(posedge clk) disable iff (!nrst)
      rise |=> pipe_r[0].code == ($past(analog_input_pair) ^ MID_CODE)
               && pipe_r[0].over == $past(analog_over))
      else $error("sample not captured on rise");

   a_pipe_shift: assert property (@(posedge clk) disable iff (!nrst)
      rise |=> pipe_r[LATENCY-1] == $past(pipe_r[LATENCY-2]))
      else $error("pipe did not advance in order");

   a_pipe_hold: assert property (@(posedge clk) disable iff (!nrst)
      !rise |=> $stable(pipe_r[0]) && $stable(pipe_r[LATENCY-1]))
      else $error("pipe moved without a rise");

   a_over_follow: assert property (@(posedge clk) disable iff (!nrst)
      fall |=> over_range_flag == $past(pipe_r[LATENCY-1].over))
      else $error("over-range flag wrong");

   a_strobe_hold: assert property (@(posedge clk) disable iff (!nrst)
      !rise && !fall |=> $stable(sample_ready_strobe))
      else $error("strobe moved without a clock edge");

   // Bookkeeping for the checks below; none of it reaches an output
   localparam int FILL_W = $clog2(LATENCY + 1);
   logic              rise_seen_r;
   logic [FILL_W-1:0] fill_cnt_r;

   // Set by a rise, cleared by the fall that publishes its word; a fall
   // with no rise since the previous one would publish a repeat
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rise_seen_r <= 1'b0;
      end else if (rise) begin
         rise_seen_r <= 1'b1;
      end else if (fall) begin
         rise_seen_r <= 1'b0;
      end
   end

   // Rises since reset, saturating at the pipe depth; until it is full the
   // words leaving the pipe are the cleared reset contents
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fill_cnt_r <= '0;
      end else if (rise && fill_cnt_r < FILL_W'(LATENCY)) begin
         fill_cnt_r <= fill_cnt_r + 1'b1;
      end
   end

   a_fall_after_rise: assert property (@(posedge clk) disable iff (!nrst)
      fall |-> rise_seen_r)
      else $error("word published without a new sample");

   a_no_double_rise: assert property (@(posedge clk) disable iff (!nrst)
      rise |-> !rise_seen_r)
      else $error("two samples taken without a word between");

   a_fill_cleared: assert property (@(posedge clk) disable iff (!nrst)
      fall && fill_cnt_r < FILL_W'(LATENCY) |=> sample_word == RST_WORD
      && !over_range_flag)
      else $error("word appeared before the pipe latency elapsed");

   // The strobe is the synced clock inverted, one cycle behind the edge
   a_strobe_tracks: assert property (@(posedge clk) disable iff (!nrst)
      sample_ready_strobe == !sclk_d_r)
      else $error("strobe does not follow the sample clock");

   // Every middle stage must take its neighbour on a rise, not only the last
   generate
      for (g = 1; g < LATENCY; g++) begin : g_stage_chk
         a_pipe_stage: assert property (@(posedge clk) disable iff (!nrst)
            rise |=> pipe_r[g] == $past(pipe_r[g-1]))
            else $error("pipe stage did not take its neighbour");
      end
   endgenerate
endmodule
`default_nettype wire

// ===== aps_capture.sv
// Capture-side model: sources the sample clock, latches words on strobe rise
`timescale 1ns/1ps
`default_nettype none
module aps_capture
   import aps_pkg::*;
(
   // Sample clock toward the converter
   output var logic                sample_clk,
   // Parallel word and strobe from the converter
   input  wire logic [SAMPLE_W-1:0] sample_word,
   input  wire logic                over_range_flag,
   input  wire logic                sample_ready_strobe
);
   aps_sample_t q[$];
   logic        armed = 1'b0;
   // Slowed 50% clock so the 10 ns system clock can resolve both phases
   initial begin
      sample_clk = 1'b0;
      #100;
      forever #62.5 sample_clk = ~sample_clk;
   end
   // The strobe settling at reset is not a word
   always @(posedge sample_clk) armed <= 1'b1;
   // Word and strobe leave on one clk edge; wait a moment so the word has settled
   always @(posedge sample_ready_strobe) begin
      if (armed) begin
         #1;
         q.push_back({over_range_flag, sample_word});
      end
   end
endmodule
`default_nettype wire

// ===== aps_sample_out_test.sv
// Testbench for the parallel sample output stage
`timescale 1ns/1ps
`default_nettype none
module aps_sample_out_test;
   import aps_pkg::*;
   logic                clk, nrst, sclk, sclk_q, fe_over, range_flag, strb;
   logic [SAMPLE_W-1:0] fe_code, sword;
   int                  bad_count = 0, n_compared = 0, k = 0;
   aps_sample_out dut (.clk(clk), .nrst(nrst), .sample_clk(sclk), .analog_input_pair(fe_code),
      .analog_over(fe_over), .sample_word(sword), .over_range_flag(range_flag),
      .sample_ready_strobe(strb));
   aps_capture cap (.sample_clk(sclk), .sample_word(sword), .over_range_flag(range_flag),
      .sample_ready_strobe(strb));
   function automatic logic [SAMPLE_W-1:0] val(int i);
      return SAMPLE_W'(i * 'h347);
   endfunction
   task automatic cmp(aps_sample_t got, aps_sample_t exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Stream of samples: input stepping by 'h347, odd-sample over-range, four-rise latency
   task automatic run_stream;
      aps_sample_t exp;
      for (int t = 0; t < 600 && cap.q.size() < 24; t++) @(negedge clk);
      if (cap.q.size() < 24) cmp('0, '1);
      for (int i = 0; i < 24 && i < cap.q.size(); i++) begin
         exp = (i < 3) ? '0 : {1'(i - 3), val(i - 3) ^ MID_CODE};
         cmp(cap.q[i], exp);
      end
   endtask
   // Next value is set just after a sample clock fall, far from the rise
   always @(negedge clk) begin
      sclk_q <= sclk;
      if (sclk_q && !sclk) begin
         k <= k + 1;
         fe_code <= val(k + 1);
         fe_over <= 1'(k + 1);
      end
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #20000;
      bad_count++;
      end_sim;
   end
   initial begin
      nrst = 1'b0;
      fe_code = val(0);
      fe_over = 1'b0;
      sclk_q = 1'b0;
      repeat (4) @(posedge clk);
      cmp({range_flag, sword}, '0);
      cmp({1'b0, 12'h000, strb}, {1'b0, 12'h000, RST_STRB});
      @(negedge clk) nrst = 1'b1;
      run_stream;
      end_sim;
   end
endmodule
`default_nettype wire
